// ==== verilog/crf_readback_framer.v ====
`timescale 1ns/10ps
`include "crf_defs.vh"

module crf_readback_framer #(
  parameter FIFO_WIDTH = 8,
  parameter FIFO_DEPTH = 2,
  parameter FIFO_PTR_W = 1
) (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_sclk,
  input  wire        i_cs_n,
  input  wire        i_din,
  output wire        o_serial_out_with_ready,
  output wire        o_serial_out_oe_n,
  output wire        o_conversion_ready_n,
  input  wire [31:0] i_main_data,
  input  wire        i_main_valid,
  input  wire [23:0] i_aux_data,
  input  wire        i_aux_valid,
  input  wire        i_conv_start,
  input  wire        i_pulse_mode,
  input  wire [7:0]  i_interface_cfg,
  input  wire        i_external_clock_flag,
  input  wire        i_low_reference_flag,
  input  wire        i_amp_output_low_flag,
  input  wire        i_amp_output_high_flag,
  input  wire        i_amp_diff_range_flag,
  input  wire        i_reset_flag,
  output wire        o_read_active
);

  // ----------------------------------------------------------------------
  // crc over a 32-bit word (low byte skipped for aux), msb first, zero initial value
  // ----------------------------------------------------------------------
  function [7:0] crf_crc32;
    input [31:0] word;
    input        aux;
    reg   [7:0]  crc;
    reg          fb;
    integer      i;
    begin
      crc = 8'h00;
      for (i = 31; i >= 0; i = i - 1) begin
        if (!(aux && i < 8)) begin
          fb  = crc[7] ^ word[i];
          crc = {crc[6:0], 1'b0} ^ (fb ? `CRF_CRC_POLY : 8'h00);
        end
      end
      crf_crc32 = crc;
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers and sclk edge detect
  // ----------------------------------------------------------------------
  reg [2:0] sclk_q;
  reg [1:0] cs_n_q;
  reg [1:0] din_q;
  wire      sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire      sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire      cs_low    = ~cs_n_q[1];

  // two flops per pin, third sclk flop only for edge finding
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q <= 3'h0;
      cs_n_q <= 2'h3;
      din_q  <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], i_sclk};
      cs_n_q <= {cs_n_q[0], i_cs_n};
      din_q  <= {din_q[0], i_din};
    end
  end

  // ----------------------------------------------------------------------
  // holding registers and new-data flags
  // ----------------------------------------------------------------------
  reg  [31:0] main_hold_q;
  reg  [23:0] aux_hold_q;
  reg         main_new_q;
  reg         aux_new_q;
  reg         reading_q;
  reg         read_aux_q;
  wire        read_done;

  // hold latest results; set wins over clear on completion
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      main_hold_q <= 32'h0000_0000;
      aux_hold_q  <= 24'h00_0000;
      main_new_q  <= 1'b0;
      aux_new_q   <= 1'b0;
    end else begin
      if (i_main_valid)
        main_hold_q <= i_main_data;
      if (i_aux_valid)
        aux_hold_q <= i_aux_data;
      if (i_main_valid)
        main_new_q <= 1'b1;
      else if (read_done && !read_aux_q)
        main_new_q <= 1'b0;
      if (i_aux_valid)
        aux_new_q <= 1'b1;
      else if (read_done && read_aux_q)
        aux_new_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // command receiver
  // ----------------------------------------------------------------------
  reg  [7:0] cmd_q;
  reg  [3:0] cmd_cnt_q;
  wire [7:0] cmd_next  = {cmd_q[6:0], din_q[1]};
  wire       cmd_last  = sclk_fall && cs_low && !reading_q && (cmd_cnt_q == `CRF_CMD_BITS - 4'h1);
  wire       hit_main  = (cmd_next == `CRF_OP_READ_MAIN_A) || (cmd_next == `CRF_OP_READ_MAIN_B);
  wire       hit_aux   = (cmd_next == `CRF_OP_READ_AUX_A) || (cmd_next == `CRF_OP_READ_AUX_B);
  wire       start_rd  = cmd_last && (hit_main || hit_aux);

  // shift opcode bits on sclk fall, frozen while a read runs
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmd_q     <= 8'h00;
      cmd_cnt_q <= 4'h0;
    end else if (!cs_low) begin
      cmd_cnt_q <= 4'h0;
    end else if (sclk_fall && !reading_q) begin
      cmd_q     <= cmd_next;
      cmd_cnt_q <= cmd_last ? 4'h0 : cmd_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // frame snapshot taken when the read command decodes
  // ----------------------------------------------------------------------
  reg  [31:0] snap_q;
  reg  [7:0]  status_q;
  reg  [7:0]  integ_q;
  reg         st_en_q;
  reg         integ_en_q;
  reg  [2:0]  frame_len_q;
  wire [1:0]  integ_mode = i_interface_cfg[`CRF_CFG_INTEG_HI:`CRF_CFG_INTEG_LO];
  wire        st_en      = i_interface_cfg[`CRF_CFG_STATUS_BIT];
  wire [31:0] snap_word  = hit_aux ? {aux_hold_q, `CRF_PAD_BYTE} : main_hold_q;
  wire [7:0]  sum3       = snap_word[31:24] + snap_word[23:16] + snap_word[15:8];
  wire [7:0]  chk_val    = sum3 + (hit_aux ? 8'h00 : snap_word[7:0]) + `CRF_CHK_OFFSET;
  wire [7:0]  crc_val    = crf_crc32(snap_word, hit_aux);
  wire        integ_en   = (integ_mode == `CRF_INTEG_CHECKSUM) || (integ_mode == `CRF_INTEG_CRC);
  wire [7:0]  status_now;

  assign status_now[`CRF_ST_AUX_NEW]  = aux_new_q;
  assign status_now[`CRF_ST_MAIN_NEW] = main_new_q;
  assign status_now[`CRF_ST_EXT_CLK]  = i_external_clock_flag;
  assign status_now[`CRF_ST_LOW_REF]  = i_low_reference_flag;
  assign status_now[`CRF_ST_AMP_LOW]  = i_amp_output_low_flag;
  assign status_now[`CRF_ST_AMP_HIGH] = i_amp_output_high_flag;
  assign status_now[`CRF_ST_AMP_DIFF] = i_amp_diff_range_flag;
  assign status_now[`CRF_ST_RESET]    = i_reset_flag;

  // capture data, status and integrity so the frame stays coherent
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      snap_q      <= 32'h0000_0000;
      status_q    <= 8'h00;
      integ_q     <= 8'h00;
      st_en_q     <= 1'b0;
      integ_en_q  <= 1'b0;
      frame_len_q <= 3'h0;
      read_aux_q  <= 1'b0;
    end else if (start_rd) begin
      snap_q      <= snap_word;
      status_q    <= status_now;
      integ_q     <= (integ_mode == `CRF_INTEG_CRC) ? crc_val : chk_val;
      st_en_q     <= st_en;
      integ_en_q  <= integ_en;
      frame_len_q <= `CRF_DATA_BYTES + {2'h0, st_en} + {2'h0, integ_en};
      read_aux_q  <= hit_aux;
    end
  end

  // ----------------------------------------------------------------------
  // byte framer: pushes the sequence into the buffer
  // ----------------------------------------------------------------------
  reg  [2:0] push_idx_q;
  reg  [7:0] frame_byte;
  wire [2:0] slot      = push_idx_q + {2'h0, ~st_en_q};
  wire       fifo_in_ready;
  wire       fifo_in_valid = reading_q && (push_idx_q < frame_len_q);

  // select byte by logical slot: status, four data bytes, integrity
  always @* begin
    case (slot)
      3'h0:    frame_byte = status_q;
      3'h1:    frame_byte = snap_q[31:24];
      3'h2:    frame_byte = snap_q[23:16];
      3'h3:    frame_byte = snap_q[15:8];
      3'h4:    frame_byte = snap_q[7:0];                  // pad for aux
      3'h5:    frame_byte = integ_en_q ? integ_q : 8'h00;
      default: frame_byte = 8'h00;
    endcase
  end

  // advance only when the buffer accepts, so a stall loses nothing
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      push_idx_q <= 3'h0;
    else if (start_rd || !reading_q)
      push_idx_q <= 3'h0;
    else if (fifo_in_valid && fifo_in_ready)
      push_idx_q <= push_idx_q + 3'h1;
  end

  // ----------------------------------------------------------------------
  // two-entry byte buffer
  // ----------------------------------------------------------------------
  reg  [FIFO_WIDTH-1:0] fifo_mem [0:FIFO_DEPTH-1];
  reg  [FIFO_PTR_W-1:0] wr_ptr_q;
  reg  [FIFO_PTR_W-1:0] rd_ptr_q;
  reg  [FIFO_PTR_W:0]   fill_q;
  wire                  fifo_out_valid = (fill_q != {(FIFO_PTR_W+1){1'b0}});
  wire                  fifo_out_ready;
  wire [FIFO_WIDTH-1:0] fifo_out_data  = fifo_mem[rd_ptr_q];
  wire                  fifo_wr        = fifo_in_valid && fifo_in_ready;
  wire                  fifo_rd        = fifo_out_valid && fifo_out_ready;
  wire                  fifo_flush     = !reading_q;
  integer               k;

  assign fifo_in_ready = (fill_q != FIFO_DEPTH[FIFO_PTR_W:0]);

  // pointers wrap at the depth; flushed whenever no read runs
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_q <= {FIFO_PTR_W{1'b0}};
      rd_ptr_q <= {FIFO_PTR_W{1'b0}};
      fill_q   <= {(FIFO_PTR_W+1){1'b0}};
      for (k = 0; k < FIFO_DEPTH; k = k + 1)
        fifo_mem[k] <= {FIFO_WIDTH{1'b0}};
    end else if (fifo_flush) begin
      wr_ptr_q <= {FIFO_PTR_W{1'b0}};
      rd_ptr_q <= {FIFO_PTR_W{1'b0}};
      fill_q   <= {(FIFO_PTR_W+1){1'b0}};
    end else begin
      if (fifo_wr) begin
        fifo_mem[wr_ptr_q] <= frame_byte;
        wr_ptr_q <= (wr_ptr_q == FIFO_DEPTH[FIFO_PTR_W-1:0] - 1'b1) ? {FIFO_PTR_W{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (fifo_rd)
        rd_ptr_q <= (rd_ptr_q == FIFO_DEPTH[FIFO_PTR_W-1:0] - 1'b1) ? {FIFO_PTR_W{1'b0}} : rd_ptr_q + 1'b1;
      if (fifo_wr && !fifo_rd)
        fill_q <= fill_q + 1'b1;
      else if (fifo_rd && !fifo_wr)
        fill_q <= fill_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // serialiser: rise shifts out, fall counts delivered bits
  // ----------------------------------------------------------------------
  reg  [7:0] out_shift_q;
  reg  [2:0] bit_cnt_q;
  reg  [5:0] falls_q;
  reg        out_bit_q;
  wire [5:0] frame_bits = {frame_len_q, 3'h0};

  assign fifo_out_ready = reading_q && sclk_rise && (bit_cnt_q == 3'h0);
  assign read_done      = reading_q && cs_low && sclk_fall && (falls_q == frame_bits - 6'h1);

  // one byte loaded per eight rises; msb leaves on the first rise
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      reading_q   <= 1'b0;
      out_shift_q <= 8'h00;
      bit_cnt_q   <= 3'h0;
      falls_q     <= 6'h00;
      out_bit_q   <= 1'b0;
    end else if (!cs_low) begin
      reading_q <= 1'b0;                          // chip select high aborts
      bit_cnt_q <= 3'h0;
      falls_q   <= 6'h00;
      out_bit_q <= 1'b0;
    end else if (start_rd) begin
      reading_q <= 1'b1;
      bit_cnt_q <= 3'h0;
      falls_q   <= 6'h00;
    end else if (reading_q) begin
      if (sclk_rise) begin
        if (bit_cnt_q == 3'h0) begin
          out_bit_q   <= fifo_out_valid ? fifo_out_data[7] : 1'b0;
          out_shift_q <= fifo_out_valid ? {fifo_out_data[6:0], 1'b0} : 8'h00;
        end else begin
          out_bit_q   <= out_shift_q[7];
          out_shift_q <= {out_shift_q[6:0], 1'b0};
        end
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (sclk_fall) begin
        falls_q <= falls_q + 6'h1;
        if (read_done) begin
          reading_q <= 1'b0;                      // one frame per command
          out_bit_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // conversion ready output
  // ----------------------------------------------------------------------
  reg ready_n_q;
  wire opcode_first_fall = sclk_fall && cs_low && !reading_q && (cmd_cnt_q == 4'h0);

  // falls with new main data, rises per conversion mode
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      ready_n_q <= 1'b1;
    else if (i_main_valid)
      ready_n_q <= 1'b0;
    else if (i_pulse_mode && i_conv_start)
      ready_n_q <= 1'b1;
    else if (!i_pulse_mode && opcode_first_fall)
      ready_n_q <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  assign o_conversion_ready_n    = ready_n_q;
  assign o_serial_out_with_ready = reading_q ? out_bit_q : ready_n_q;
  assign o_serial_out_oe_n       = ~cs_low;
  assign o_read_active           = reading_q;

endmodule // crf_readback_framer

// ==== verilog/crf_defs.vh ====
`ifndef CRF_DEFS_VH
`define CRF_DEFS_VH

// ----------------------------------------------------------------------
// read opcodes
// ----------------------------------------------------------------------
`define CRF_OP_READ_MAIN_A   8'h12
`define CRF_OP_READ_MAIN_B   8'h13
`define CRF_OP_READ_AUX_A    8'h14
`define CRF_OP_READ_AUX_B    8'h15

// ----------------------------------------------------------------------
// interface configuration register (address 02h) layout
// ----------------------------------------------------------------------
`define CRF_CFG_ADDR         8'h02
`define CRF_CFG_STATUS_BIT   2
`define CRF_CFG_INTEG_HI     1
`define CRF_CFG_INTEG_LO     0
`define CRF_INTEG_OFF        2'h0
`define CRF_INTEG_CHECKSUM   2'h1
`define CRF_INTEG_CRC        2'h2

// ----------------------------------------------------------------------
// status byte field positions
// ----------------------------------------------------------------------
`define CRF_ST_AUX_NEW       7
`define CRF_ST_MAIN_NEW      6
`define CRF_ST_EXT_CLK       5
`define CRF_ST_LOW_REF       4
`define CRF_ST_AMP_LOW       3
`define CRF_ST_AMP_HIGH      2
`define CRF_ST_AMP_DIFF      1
`define CRF_ST_RESET         0

// ----------------------------------------------------------------------
// integrity byte constants and frame sizes
// ----------------------------------------------------------------------
`define CRF_CHK_OFFSET       8'h9b
`define CRF_CRC_POLY         8'h07
`define CRF_PAD_BYTE         8'h00
`define CRF_MAIN_BITS        32
`define CRF_AUX_BITS         24
`define CRF_DATA_BYTES       3'h4
`define CRF_CMD_BITS         4'h8

`endif

// ==== testbench/crf_framer_properties.sv ====
`timescale 1ns/10ps
// pin-level checks of ready, select and frame length
module crf_framer_properties (
  input wire       i_clk,
  input wire       i_sys_rst,
  input wire       i_sclk,
  input wire       i_cs_n,
  input wire       i_main_valid,
  input wire       i_conv_start,
  input wire       i_pulse_mode,
  input wire [7:0] i_interface_cfg,
  input wire       o_serial_out_with_ready,
  input wire       o_serial_out_oe_n,
  input wire       o_conversion_ready_n,
  input wire       o_read_active
);
  logic       sclk_q;
  logic [6:0] fall_cnt_q;
  logic [6:0] bits_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // counts clock falls in a read; frame length is latched while idle
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q <= 1'b0;
      fall_cnt_q <= 7'h0;
      bits_q <= 7'h0;
    end else begin
      sclk_q <= i_sclk;
      if (!o_read_active)
        fall_cnt_q <= 7'h0;
      else if (sclk_q && !i_sclk)
        fall_cnt_q <= fall_cnt_q + 7'h1;
      if (!o_read_active)
        bits_q <= 7'h20 + (i_interface_cfg[2] ? 7'h8 : 7'h0) + (^i_interface_cfg[1:0] ? 7'h8 : 7'h0);
    end
  end
  sequence s_opcode_fall;
    !i_pulse_mode && !i_cs_n && !o_read_active && $fell(i_sclk);
  endsequence
  sequence s_ready_back;
    ##[2:6] o_conversion_ready_n;
  endsequence
  AST_READY_OPCODE: assert property (s_opcode_fall |-> s_ready_back)
    else $error("ready not raised by opcode clock fall");
  AST_READY_SET: assert property (i_main_valid |=> !o_conversion_ready_n)
    else $error("ready not low after new data");
  AST_READY_CAUSE: assert property ($fell(o_conversion_ready_n) |-> $past(i_main_valid))
    else $error("ready fell without new data");
  AST_PULSE_HOLD: assert property (i_pulse_mode && !o_conversion_ready_n && !i_conv_start |=> !o_conversion_ready_n)
    else $error("ready left low state in pulse mode");
  AST_ABORT: assert property ($rose(i_cs_n) |-> ##[1:4] !o_read_active)
    else $error("read not aborted by select high");
  AST_DECODE_EDGE: assert property ($rose(o_read_active) |-> !i_sclk && !i_cs_n)
    else $error("read started outside a low clock phase");
  AST_FRAME_LEN: assert property ($fell(o_read_active) && !i_cs_n |-> fall_cnt_q == bits_q)
    else $error("frame length wrong");
  AST_IDLE_PIN: assert property ((!o_serial_out_oe_n && !o_read_active && $stable(o_conversion_ready_n))[*3]
    |-> o_serial_out_with_ready == o_conversion_ready_n)
    else $error("data pin does not follow ready");
  AST_SELECT_OE: assert property ((!i_cs_n)[*4] |-> !o_serial_out_oe_n)
    else $error("data pin not driven while selected");
endmodule // crf_framer_properties

bind crf_readback_framer crf_framer_properties i_crf_framer_properties (.*);

// ==== testbench/crf_host_model.sv ====
`timescale 1ns/10ps
// host serial controller: clock idles low, data changes on rise
module crf_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input  wire  i_dout
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  // one byte msb first, answer sampled at each fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      o_sclk = 1'b1;
      o_din = tx[b];
      #100;
      o_sclk = 1'b0;
      rx[b] = i_dout;
      #100;
    end
  endtask
  // select and send one read opcode, at any time
  task automatic start(input logic [7:0] op);
    logic [7:0] unused;
    o_cs_n = 1'b0;
    #100;
    xfer(op, unused);
  endtask
  // deselect after the last fall
  task automatic stop;
    #100;
    o_cs_n = 1'b1;
    #100;
  endtask
endmodule // crf_host_model

// ==== testbench/test_conversion_readback_framer.sv ====
`timescale 1ns/10ps
module test_conversion_readback_framer;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_main_valid = 1'b0;
  logic        i_aux_valid = 1'b0;
  logic        i_conv_start = 1'b0;
  logic        i_pulse_mode = 1'b0;
  logic [31:0] i_main_data = 32'h0;
  logic [23:0] i_aux_data = 24'h0;
  logic [7:0]  i_interface_cfg = 8'h0;
  logic [5:0]  flags = 6'h0;
  wire         i_sclk, i_cs_n, i_din;
  wire         o_serial_out_with_ready, o_serial_out_oe_n, o_conversion_ready_n, o_read_active;
  wire         i_external_clock_flag = flags[5];
  wire         i_low_reference_flag = flags[4];
  wire         i_amp_output_low_flag = flags[3];
  wire         i_amp_output_high_flag = flags[2];
  wire         i_amp_diff_range_flag = flags[1];
  wire         i_reset_flag = flags[0];
  wire         pin = o_serial_out_oe_n ? 1'bz : o_serial_out_with_ready;
  int          bad_count = 0, num_checks = 0, cycles = 0, seed = 88530;
  bit          main_new = 0, aux_new = 0, rdy = 1;
  logic [7:0]  exp_q[$], got;
  logic [7:0]  cfgs[8] = '{8'h04, 8'h00, 8'h05, 8'h06, 8'h07, 8'h01, 8'h02, 8'h03};

  crf_readback_framer i_crf_readback_framer (.*);
  crf_host_model host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_din(i_din), .i_dout(pin));

  initial forever #12.5 i_clk = ~i_clk;
  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (exp !== seen) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  // one-cycle result pulse from a converter, noted in the model
  task automatic new_data(input bit aux);
    @(negedge i_clk);
    if (aux) begin
      i_aux_data = 24'($random(seed));
      i_aux_valid = 1'b1;
      aux_new = 1;
    end else begin
      i_main_data = $random(seed);
      i_main_valid = 1'b1;
      main_new = 1;
      rdy = 0;
    end
    @(negedge i_clk);
    i_aux_valid = 1'b0;
    i_main_valid = 1'b0;
    @(negedge i_clk);
    check("ready after data", rdy, o_conversion_ready_n);
  endtask
  // expected frame: status, data msb first, pad, integrity
  task automatic build(input bit aux);
    logic [7:0] s;
    logic [7:0] c;
    logic [7:0] b;
    exp_q = {};
    s = 8'h9b;
    c = 8'h00;
    if (i_interface_cfg[2]) exp_q.push_back({aux_new, main_new, flags});
    for (int i = aux ? 2 : 3; i >= 0; i--) begin
      b = aux ? i_aux_data[8*i +: 8] : i_main_data[8*i +: 8];
      exp_q.push_back(b);
      s += b;
      c ^= b;
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    if (aux) exp_q.push_back(8'h00);
    if (i_interface_cfg[1:0] == 2'h1) exp_q.push_back(s);
    if (i_interface_cfg[1:0] == 2'h2) exp_q.push_back(c);
  endtask
  // full command read with an opcode repeated on the data line meanwhile
  task automatic do_read(input logic [7:0] op, input logic [7:0] cfg);
    bit aux;
    aux = op[2];
    @(negedge i_clk);
    i_interface_cfg = cfg;
    flags = 6'($random(seed));
    build(aux);
    host.start(op);
    if (!i_pulse_mode) rdy = 1;
    check("ready after opcode", rdy, o_conversion_ready_n);
    foreach (exp_q[i]) begin
      host.xfer(8'h12, got);
      check("frame byte", exp_q[i], got);
    end
    host.stop;
    check("read done", 0, o_read_active);
    if (aux) aux_new = 0;
    else main_new = 0;
  endtask

  initial begin
    repeat (10) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    do_read(8'h12, 8'h04);
    for (int k = 0; k < 8; k++) begin
      new_data(k[1]);
      if (k > 3) new_data(!k[1]);
      do_read(8'h12 + k[1:0], cfgs[k]);
      do_read(8'h12 + k[1:0], cfgs[k]);
    end
    // abort a read after its status byte; the flag must survive
    new_data(0);
    @(negedge i_clk);
    i_interface_cfg = 8'h04;
    build(0);
    host.start(8'h13);
    host.xfer(8'h12, got);
    host.stop;
    check("aborted status", exp_q[0], got);
    check("aborted", 0, o_read_active);
    do_read(8'h13, 8'h04);
    // pulse mode: ready stays low through a read until a start
    i_pulse_mode = 1'b1;
    new_data(0);
    do_read(8'h12, 8'h06);
    @(negedge i_clk);
    i_conv_start = 1'b1;
    rdy = 1;
    @(negedge i_clk);
    i_conv_start = 1'b0;
    @(negedge i_clk);
    check("ready after start", rdy, o_conversion_ready_n);
    tally_and_finish;
  end
endmodule // test_conversion_readback_framer
